//--- design/fer_params.svh
// constants of the receive descramble and alignment front end
// assumes one recovered bit per clk_i cycle
`ifndef FER_PARAMS_SVH
`define FER_PARAMS_SVH
`define FER_CLK_MHZ     200
`define FER_HOLD_US     722
`define FER_IDLE_RUN    40
`define FER_IDLE_ONES   30
`define FER_LFSR_W      11
`define FER_TAP_HI      10
`define FER_TAP_LO      8
`define FER_GROUP_W     5
`define FER_SSD_W       10
`define FER_SSD_PAIR    10'h311
`define FER_IDLE_GROUP  5'h1f
`define FER_LAST_SLOT   3'h4
`endif

//--- design/fer_pkg.sv
// types of the receive descramble and alignment front end
// constants live in fer_params.svh
package fer_pkg;
  // static configuration from the management side
  typedef struct packed {
    logic fiber_sel;
    logic loopback;
    logic bypass_nrzi;
    logic bypass_descr;
    logic bypass_align;
  } fer_cfg_t;

  // one aligned code-group
  typedef struct packed {
    logic       valid;
    logic       idle;
    logic [4:0] code;
  } fer_group_t;

  typedef enum logic [1:0] {
    FER_DSC_ACQ  = 2'b01,
    FER_DSC_LOCK = 2'b10
  } fer_dsc_state_t;

  typedef enum logic [1:0] {
    FER_ALN_HUNT = 2'b01,
    FER_ALN_SYNC = 2'b10
  } fer_aln_state_t;
endpackage : fer_pkg

//--- design/fer_rx_front.sv
// 100 Mbit/s receive front end: source select, nrzi decode,
// descrambler with hold timer, code-group alignment
// assumes bits arrive from timing recovery logic on clk_i, one per cycle
//
// Notes on behaviour
// - one recovered bit processed per clock
// - source selectable: twisted pair or fibre input
// - nrzi to nrz, transition gives one
// - nrz stream carries no code-group boundary
// - lock after 40-bit idle burst, load lfsr
// - locked: xor each bit with lfsr output
// - lock starts 722 us hold countdown
// - 30 consecutive ones restart the countdown
// - countdown expiry drops lock, reacquire
// - aligner consumes unaligned descrambled stream
// - boundary found from 11000 then 10001
// - then group every five bits, fixed boundary
// - each coding function has a bypass
// - internal loopback of the 100M datapath
// - idle code-group is 11111, no data
`timescale 1ns/1ps
`default_nettype none
`include "fer_params.svh"

module fer_rx_front
  import fer_pkg::*;
#(
  parameter int HOLD_CYCLES = `FER_HOLD_US * `FER_CLK_MHZ
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire fer_cfg_t   cfg_i,
  input  wire logic       tp_bit_i,
  input  wire logic       fx_bit_i,
  input  wire logic       loop_bit_i,
  output logic            nrz_bit_o,
  output logic            descr_bit_o,
  output logic            locked_o,
  output logic            aligned_o,
  output fer_group_t      group_o
);

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int RW = $clog2(`FER_IDLE_RUN + 1);
  localparam int OW = $clog2(`FER_IDLE_ONES + 1);

  // ==================================================================
  // source select and nrzi decode
  // ==================================================================
  logic line_bit;
  logic prev_line_reg;
  logic prev_line_next;
  logic nrz_bit_reg;
  logic nrz_bit_next;

  always_comb begin
    // loopback wins so the tx path can be checked with no cable
    if (cfg_i.loopback) begin
      line_bit = loop_bit_i;
    end else if (cfg_i.fiber_sel) begin
      line_bit = fx_bit_i;
    end else begin
      line_bit = tp_bit_i;
    end
    prev_line_next = line_bit;
    if (cfg_i.bypass_nrzi) begin
      nrz_bit_next = line_bit;
    end else begin
      nrz_bit_next = line_bit ^ prev_line_reg;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_line_reg <= 1'b0;
      nrz_bit_reg   <= 1'b0;
    end else begin
      prev_line_reg <= prev_line_next;
      nrz_bit_reg   <= nrz_bit_next;
    end
  end

  assign nrz_bit_o = nrz_bit_reg;

  nrzi_conv_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !cfg_i.bypass_nrzi |=> nrz_bit_reg == $past(line_bit ^ prev_line_reg))
    else $error("nrz bit is not the transition of the line");

  source_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !cfg_i.loopback && cfg_i.fiber_sel |-> line_bit == fx_bit_i)
    else $error("fibre source not selected");

  // ==================================================================
  // descrambler and hold timer
  // ==================================================================
  // keystream k[n] = k[n-11] ^ k[n-9]; idle plaintext is all ones,
  // so during idle the inverted nrz bit is the keystream itself
  fer_dsc_state_t              dsc_reg;
  fer_dsc_state_t              dsc_next;
  logic [`FER_LFSR_W-1:0]      lfsr_reg;
  logic [`FER_LFSR_W-1:0]      lfsr_next;
  logic [RW-1:0]               run_reg;
  logic [RW-1:0]               run_next;
  logic [HW-1:0]               hold_reg;
  logic [HW-1:0]               hold_next;
  logic [OW-1:0]               ones_reg;
  logic [OW-1:0]               ones_next;
  logic                        descr_bit_reg;
  logic                        descr_bit_next;
  logic                        key_bit;
  logic                        guess_bit;
  logic                        plain_bit;
  logic                        lock_eff;

  function automatic logic lfsr_out(input logic [`FER_LFSR_W-1:0] s);
    lfsr_out = s[`FER_TAP_HI] ^ s[`FER_TAP_LO];
  endfunction : lfsr_out

  always_comb begin
    dsc_next  = dsc_reg;
    run_next  = run_reg;
    hold_next = hold_reg;
    ones_next = ones_reg;
    key_bit   = lfsr_out(lfsr_reg);
    guess_bit = ~nrz_bit_reg;
    plain_bit = nrz_bit_reg ^ key_bit;
    lfsr_next = {lfsr_reg[`FER_LFSR_W-2:0], key_bit};
    unique case (dsc_reg)
      FER_DSC_ACQ: begin
        // history of inverted bits; a run counts bits that the
        // recurrence predicted, which only holds during idle
        lfsr_next = {lfsr_reg[`FER_LFSR_W-2:0], guess_bit};
        ones_next = '0;
        hold_next = HW'(HOLD_CYCLES);
        if (guess_bit == key_bit) begin
          run_next = run_reg + RW'(1);
        end else begin
          run_next = '0;
        end
        if (guess_bit == key_bit && run_reg == RW'(`FER_IDLE_RUN - 1)) begin
          dsc_next  = FER_DSC_LOCK;
          run_next  = '0;
          hold_next = HW'(HOLD_CYCLES);
        end
      end
      FER_DSC_LOCK: begin
        if (plain_bit) begin
          ones_next = ones_reg + OW'(1);
        end else begin
          ones_next = '0;
        end
        if (plain_bit && ones_reg == OW'(`FER_IDLE_ONES - 1)) begin
          hold_next = HW'(HOLD_CYCLES);
          ones_next = '0;
        end else if (hold_reg == '0) begin
          dsc_next  = FER_DSC_ACQ;
          lfsr_next = '0;
          ones_next = '0;
          run_next  = '0;
        end else begin
          hold_next = hold_reg - HW'(1);
        end
      end
    endcase
    if (cfg_i.bypass_descr) begin
      descr_bit_next = nrz_bit_reg;
    end else if (dsc_reg == FER_DSC_LOCK) begin
      descr_bit_next = plain_bit;
    end else begin
      descr_bit_next = nrz_bit_reg;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dsc_reg       <= FER_DSC_ACQ;
      lfsr_reg      <= '0;
      run_reg       <= '0;
      hold_reg      <= '0;
      ones_reg      <= '0;
      descr_bit_reg <= 1'b0;
    end else begin
      dsc_reg       <= dsc_next;
      lfsr_reg      <= lfsr_next;
      run_reg       <= run_next;
      hold_reg      <= hold_next;
      ones_reg      <= ones_next;
      descr_bit_reg <= descr_bit_next;
    end
  end

  // with the descrambler bypassed the stream counts as in lock
  assign lock_eff    = cfg_i.bypass_descr || dsc_reg == FER_DSC_LOCK;
  assign locked_o    = dsc_reg == FER_DSC_LOCK;
  assign descr_bit_o = descr_bit_reg;

  lock_acq_a: assert property (@(posedge clk_i) disable iff (reset_i)
    dsc_reg == FER_DSC_ACQ ##1 dsc_reg == FER_DSC_LOCK
      |-> $past(run_reg) == RW'(`FER_IDLE_RUN - 1))
    else $error("lock taken without a full idle burst");

  descr_xor_a: assert property (@(posedge clk_i) disable iff (reset_i)
    dsc_reg == FER_DSC_LOCK && !cfg_i.bypass_descr
      |=> descr_bit_reg == $past(nrz_bit_reg ^ lfsr_out(lfsr_reg)))
    else $error("descrambled bit is not line xor keystream");

  lock_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(dsc_reg == FER_DSC_LOCK) |-> hold_reg == HW'(HOLD_CYCLES))
    else $error("hold timer not loaded at lock");

  hold_reload_a: assert property (@(posedge clk_i) disable iff (reset_i)
    dsc_reg == FER_DSC_LOCK && plain_bit && ones_reg == OW'(`FER_IDLE_ONES - 1)
      |=> hold_reg == HW'(HOLD_CYCLES) && ones_reg == '0 && dsc_reg == FER_DSC_LOCK)
    else $error("idle run did not restart the hold timer");

  hold_expire_a: assert property (@(posedge clk_i) disable iff (reset_i)
    dsc_reg == FER_DSC_LOCK && hold_reg == '0
      && !(plain_bit && ones_reg == OW'(`FER_IDLE_ONES - 1))
      |=> dsc_reg == FER_DSC_ACQ && run_reg == '0)
    else $error("lock held past hold timer expiry");

  // ==================================================================
  // code-group alignment
  // ==================================================================
  // nrz and descrambled streams carry no boundary until the j/k pair
  fer_aln_state_t           aln_reg;
  fer_aln_state_t           aln_next;
  logic [`FER_SSD_W-1:0]    win_reg;
  logic [`FER_SSD_W-1:0]    win_next;
  logic [2:0]               slot_reg;
  logic [2:0]               slot_next;
  fer_group_t               group_reg;
  fer_group_t               group_next;
  logic [`FER_SSD_W-1:0]    win_now;
  logic                     ssd_seen;

  always_comb begin
    aln_next   = aln_reg;
    slot_next  = slot_reg;
    group_next = '0;
    win_now    = {win_reg[`FER_SSD_W-2:0], descr_bit_reg};
    // pre-lock bits are still scrambled; keep them out of the search
    win_next   = lock_eff ? win_now : '0;
    ssd_seen   = win_now == `FER_SSD_PAIR;
    unique case (aln_reg)
      FER_ALN_HUNT: begin
        slot_next = '0;
        if (cfg_i.bypass_align) begin
          aln_next = FER_ALN_SYNC;
        end else if (lock_eff && ssd_seen) begin
          aln_next = FER_ALN_SYNC;
        end
      end
      FER_ALN_SYNC: begin
        if (slot_reg == `FER_LAST_SLOT) begin
          slot_next        = '0;
          group_next.valid = 1'b1;
          group_next.code  = win_now[`FER_GROUP_W-1:0];
          group_next.idle  = win_now[`FER_GROUP_W-1:0] == `FER_IDLE_GROUP;
        end else begin
          slot_next = slot_reg + 3'h1;
        end
        if (!lock_eff && !cfg_i.bypass_align) begin
          aln_next   = FER_ALN_HUNT;
          slot_next  = '0;
          group_next = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      aln_reg   <= FER_ALN_HUNT;
      win_reg   <= '0;
      slot_reg  <= '0;
      group_reg <= '0;
    end else begin
      aln_reg   <= aln_next;
      win_reg   <= win_next;
      slot_reg  <= slot_next;
      group_reg <= group_next;
    end
  end

  assign aligned_o = aln_reg == FER_ALN_SYNC;
  assign group_o   = group_reg;

  align_found_a: assert property (@(posedge clk_i) disable iff (reset_i)
    aln_reg == FER_ALN_HUNT && lock_eff && ssd_seen
      |=> aln_reg == FER_ALN_SYNC && slot_reg == 3'h0)
    else $error("delimiter pair did not set the boundary");

  group_space_a: assert property (@(posedge clk_i) disable iff (reset_i)
    group_reg.valid ##1 aln_reg == FER_ALN_SYNC [*4] |-> !group_reg.valid)
    else $error("code-groups closer than five bits");

  group_first_a: assert property (@(posedge clk_i) disable iff (reset_i)
    aln_reg == FER_ALN_HUNT ##1 (aln_reg == FER_ALN_SYNC && (lock_eff || cfg_i.bypass_align)) [*5]
      |=> group_reg.valid)
    else $error("first code-group not five bits after boundary");

  unlock_hunt_a: assert property (@(posedge clk_i) disable iff (reset_i)
    aln_reg == FER_ALN_SYNC && !lock_eff && !cfg_i.bypass_align
      |=> aln_reg == FER_ALN_HUNT && !group_reg.valid)
    else $error("boundary kept after loss of lock");

  idle_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
    group_reg.valid |-> group_reg.idle == (group_reg.code == `FER_IDLE_GROUP))
    else $error("idle flag wrong");

endmodule : fer_rx_front

`default_nettype wire

//--- dv/fer_line_model.sv
// far-end model: scrambler and nrzi line coder feeding the receive front end
// assumes plain_i changes just after the rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none

module fer_line_model #(
  parameter logic [10:0] SEED = 11'h5a3  // any nonzero start state
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic plain_i,
  output logic      line_o
);
  // ==========================================================
  // scrambler and line coder, one line bit per cycle
  logic [10:0] lfsr_reg;
  logic [10:0] lfsr_next;
  logic        line_reg;
  logic        line_next;
  logic        key;

  always_comb begin
    key       = lfsr_reg[10] ^ lfsr_reg[8];
    lfsr_next = {lfsr_reg[9:0], key};
    line_next = line_reg ^ (plain_i ^ key);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lfsr_reg <= SEED;
      line_reg <= 1'b0;
    end else begin
      lfsr_reg <= lfsr_next;
      line_reg <= line_next;
    end
  end

  assign line_o = line_reg;
endmodule : fer_line_model

`default_nettype wire

//--- dv/fer_rx_front_tb_top.sv
// testbench: receive front end against the line model and a queue reference
// assumes the package, the design and the line model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end

module fer_rx_front_tb_top
  import fer_pkg::*;
;
  // ==========================================================
  // signals
  localparam int HOLD = 200;  // short hold so expiry fits the run
  logic       clk_i;
  logic       reset_i;
  logic       plain;
  logic       use_model;
  logic       tp_r;
  logic       fx_r;
  logic       lp_r;
  logic       line;
  logic       l;
  logic       lp;
  logic       e;
  fer_cfg_t   cfg;
  logic       nrz_bit_o;
  logic       descr_bit_o;
  logic       locked_o;
  logic       aligned_o;
  fer_group_t group_o;
  int         failures;
  int         n_checks;
  logic [5:0] exp_q[$];
  logic [5:0] got_q[$];
  logic [4:0] cfgs[5] = '{5'h00, 5'h10, 5'h18, 5'h04, 5'h01};

  fer_line_model fer_line_model_i (.clk_i(clk_i), .reset_i(reset_i), .plain_i(plain), .line_o(line));

  fer_rx_front #(.HOLD_CYCLES(HOLD)) fer_rx_front_i (
    .clk_i(clk_i), .reset_i(reset_i), .cfg_i(cfg),
    .tp_bit_i(use_model ? line : tp_r), .fx_bit_i(fx_r), .loop_bit_i(lp_r),
    .nrz_bit_o(nrz_bit_o), .descr_bit_o(descr_bit_o), .locked_o(locked_o),
    .aligned_o(aligned_o), .group_o(group_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // valid stands one cycle, so sample it mid-cycle
  always @(negedge clk_i) begin
    if (group_o.valid === 1'b1) got_q.push_back({group_o.idle, group_o.code});
  end

  // ==========================================================
  // tasks
  task automatic results();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task automatic step(input logic b);
    @(posedge clk_i);
    #1;
    plain = b;
    fx_r  = b;
  endtask : step

  task automatic send(input logic [4:0] s);
    for (int k = 4; k >= 0; k--) step(s[k]);
  endtask : send

  task automatic rst(input logic [4:0] c);
    @(posedge clk_i);
    #1;
    reset_i = 1'b1;
    cfg     = fer_cfg_t'(c);
    plain   = 1'b1;
    fx_r    = 1'b1;
    repeat (16) @(posedge clk_i);
    `CHK({locked_o, aligned_o, group_o, nrz_bit_o}, 10'h000)
    #1;
    reset_i = 1'b0;
  endtask : rst

  // idle or random bits until lock reaches want, then check the count
  task automatic wait_lock(input logic want, input int lo, input int hi, input logic rnd);
    int n;
    n = 0;
    while (locked_o !== want && n <= hi) begin
      step(rnd ? 1'($urandom) : 1'b1);
      n++;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask : wait_lock

  task automatic align_run();
    logic [4:0] s;
    got_q.delete();
    exp_q.delete();
    repeat (20 + $urandom % 5) step(1'b1);
    send(5'h18);
    send(5'h11);
    for (int i = 0; i < 12; i++) begin
      s = (i < 8) ? 5'($urandom) : 5'h1f;
      exp_q.push_back({s == 5'h1f, s});
      send(s);
    end
    repeat (20) step(1'b1);
    `CHK(aligned_o, 1'b1)
    `CHK(got_q.size() >= 12, 1'b1)
    for (int i = 0; i < 12; i++) `CHK(got_q[i], exp_q[i])
  endtask : align_run

  // ==========================================================
  // watchdog, about four times the expected run
  initial begin
    #(5000 * 5);
    failures++;
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    failures  = 0;
    n_checks  = 0;
    reset_i   = 1'b1;
    cfg       = '0;
    plain     = 1'b1;
    use_model = 1'b0;
    tp_r      = 1'b0;
    fx_r      = 1'b0;
    lp_r      = 1'b0;
    lp        = 1'b0;
    e         = 1'b0;
    void'($urandom(32'h9ab648ab));
    rst(5'h00);
    // source select and line decode against the bit model
    foreach (cfgs[j]) begin
      cfg = fer_cfg_t'(cfgs[j]);
      for (int i = 0; i < 40; i++) begin
        @(posedge clk_i);
        #1;
        if (i > 1) `CHK(nrz_bit_o, e)
        tp_r = 1'($urandom);
        fx_r = 1'($urandom);
        lp_r = 1'($urandom);
        l    = cfg.loopback ? lp_r : (cfg.fiber_sel ? fx_r : tp_r);
        e    = cfg.bypass_nrzi ? l : l ^ lp;
        lp   = l;
      end
      `CHK(aligned_o, cfg.bypass_align)
    end
    rst(5'h00);
    use_model = 1'b1;
    wait_lock(1'b1, 40, 70, 1'b0);
    repeat (300) step(1'b1);
    `CHK(locked_o, 1'b1)
    `CHK(descr_bit_o, 1'b1)
    align_run();
    repeat (60) step(1'b1);
    // a zero ends the idle run, so random ones cannot stretch it into a late reload
    step(1'b0);
    // last reload lies within the final 30 idle bits
    wait_lock(1'b0, HOLD - 35, HOLD + 8, 1'b1);
    step(1'b1);
    step(1'b1);
    `CHK(aligned_o, 1'b0)
    wait_lock(1'b1, 40, 70, 1'b0);
    // fibre source with line decode and descrambler bypassed
    rst(5'h16);
    align_run();
    results();
  end
endmodule : fer_rx_front_tb_top

`default_nettype wire
